/* File: design/bcregs_pkg.sv */
// Constants for the message control register bank
package bcregs_pkg;

  // Register indices; the AXI byte address is four times the index
  localparam logic [13:0] IDX_BC_WIN   = 14'h3ff3;
  localparam logic [13:0] IDX_WC_OFS   = 14'h3ff4;
  localparam logic [13:0] IDX_BITS_SEL = 14'h3ff5;
  localparam logic [13:0] IDX_REPEAT   = 14'h3ff6;
  localparam logic [13:0] IDX_FLAG_CLR = 14'h3ff7;
  localparam logic [13:0] IDX_IRQ_RST  = 14'h3ff8;
  localparam logic [13:0] IDX_RT_DLY   = 14'h3ff9;
  localparam logic [13:0] IDX_FLAGS    = 14'h3ffa;
  localparam logic [13:0] IDX_IRQ_EN   = 14'h3ffb;
  localparam logic [13:0] IDX_START    = 14'h3ffc;
  localparam logic [13:0] IDX_STATUS   = 14'h3ffd;

  // Event flag positions, shared by flags, clear and enable registers
  localparam int unsigned FLG_WAIT = 0;
  localparam int unsigned FLG_DONE = 1;
  localparam int unsigned FLG_EOF  = 2;
  localparam int unsigned FLG_ERR  = 3;
  localparam logic [7:0]  FLAGS_MASK = 8'h0f;
  localparam logic [7:0]  IRQ_MASK   = 8'h0e;

  // Start register and status register fields
  localparam int unsigned START_RUN  = 0;
  localparam int unsigned START_LOOP = 2;
  localparam logic [7:0]  START_MASK = 8'h05;
  localparam int unsigned STAT_HALT  = 4;

  // Timing: 8 ns clock, 155 ns response-time step
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned TICK_PS       = 155000;
  localparam int unsigned RT_MIN_NS     = 4000;
  localparam int unsigned BC_MIN_NS     = 2000;
  localparam int unsigned RT_MIN_CYC    = (RT_MIN_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned BC_MIN_CYC    = (BC_MIN_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned STEP_CYC_MAX  = (TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Word shaping
  localparam logic [2:0] BITS_CODE_MAX = 3'h6;
  localparam logic [4:0] BITS_BASE     = 5'h11;
  localparam logic [4:0] BITS_NORMAL   = 5'h14;
  localparam logic [5:0] WC_FULL       = 6'h20;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : bcregs_pkg

/* File: design/dead_time_timer.sv */
// Bus dead-time timer: fixed minimum plus a count of 155 ns steps
`timescale 1ns/1ps
`default_nettype none
module dead_time_timer
  import bcregs_pkg::*;
#(
  parameter int unsigned BASE_CYC = RT_MIN_CYC
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       start,
  input  wire logic       cancel,
  input  wire logic [7:0] steps,
  output logic            expire
);
  typedef enum logic [2:0] {T_IDLE = 3'b001, T_BASE = 3'b010, T_STEP = 3'b100} phase_t;
  typedef struct packed {
    phase_t      phase;
    logic [9:0]  cnt;
    logic [7:0]  steps;
    logic [17:0] acc;
    logic        expire;
    logic [15:0] elapsed;
  } tmr_t;

  localparam logic [17:0] STEP_PS  = 18'(CLK_PERIOD_PS);
  localparam logic [17:0] TICK_LIM = 18'(TICK_PS);

  tmr_t s_r;
  tmr_t s_nxt;

  // Fractional accumulator keeps the 155 ns step exact on average
  always_comb begin
    s_nxt = s_r;
    s_nxt.expire = 1'b0;
    if (s_r.phase != T_IDLE) begin
      s_nxt.elapsed = s_r.elapsed + 16'h1;
    end
    unique case (s_r.phase)
      T_IDLE: if (start) begin
        s_nxt.phase   = T_BASE;
        s_nxt.cnt     = 10'(BASE_CYC - 1);
        s_nxt.steps   = steps;
        s_nxt.elapsed = '0;
      end
      T_BASE: if (cancel) begin
        s_nxt.phase = T_IDLE;
      end else if (s_r.cnt == '0) begin
        s_nxt.phase = T_STEP;
        s_nxt.acc   = '0;
      end else begin
        s_nxt.cnt = s_r.cnt - 10'h1;
      end
      T_STEP: if (cancel) begin
        s_nxt.phase = T_IDLE;
      end else if (s_r.steps == '0) begin
        s_nxt.expire = 1'b1;
        s_nxt.phase  = T_IDLE;
      end else if (s_r.acc + STEP_PS >= TICK_LIM) begin
        s_nxt.acc   = s_r.acc + STEP_PS - TICK_LIM;
        s_nxt.steps = s_r.steps - 8'h1;
      end else begin
        s_nxt.acc = s_r.acc + STEP_PS;
      end
      default: s_nxt.phase = T_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '{phase: T_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign expire = s_r.expire;

  // Expiry never before the fixed minimum, never after the step allowance
  a_dead_min_time: assert property (@(posedge aclk) disable iff (!aresetn)
    s_r.expire |-> s_r.elapsed >= 16'(BASE_CYC))
    else $error("dead time expired before minimum");
  a_dead_max_time: assert property (@(posedge aclk) disable iff (!aresetn)
    s_r.expire |-> s_r.elapsed <= 16'(BASE_CYC) + 16'(steps) * 16'(STEP_CYC_MAX) + 16'h3)
    else $error("dead time overran step allowance");
endmodule : dead_time_timer
`default_nettype wire

/* File: design/injection_shaper.sv */
// Bit-count and word-count error injection for the current message
`timescale 1ns/1ps
`default_nettype none
module injection_shaper
  import bcregs_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       inj_bits,
  input  wire logic       inj_words,
  input  wire logic [2:0] bits_code,
  input  wire logic [4:0] cmd_wc,
  input  wire logic [7:0] wc_ofs,
  output logic      [4:0] bits_per_word,
  output logic      [5:0] data_words
);
  typedef struct packed {
    logic [4:0] bits;
    logic [5:0] words;
  } shp_t;

  shp_t       s_r;
  shp_t       s_nxt;
  logic [6:0] base;
  logic [6:0] sum;

  // Code 7 is undefined and falls back to a valid word
  always_comb begin
    s_nxt = s_r;
    s_nxt.bits = BITS_NORMAL;
    if (inj_bits && bits_code <= BITS_CODE_MAX) begin
      s_nxt.bits = BITS_BASE + 5'(bits_code);
    end
    base = (cmd_wc == '0) ? {1'b0, WC_FULL} : {2'b00, cmd_wc};
    sum  = base;
    if (inj_words) begin
      sum = base + {{4{wc_ofs[7]}}, wc_ofs[2:0]};
    end
    // A negative result cannot be sent; clamp to none
    s_nxt.words = sum[6] ? '0 : sum[5:0];
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '{bits: BITS_NORMAL, words: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bits_per_word = s_r.bits;
  assign data_words    = s_r.words;

  a_bits_normal: assert property (@(posedge aclk) disable iff (!aresetn)
    !inj_bits |=> bits_per_word == BITS_NORMAL)
    else $error("bit count altered without injection");
  a_bits_code: assert property (@(posedge aclk) disable iff (!aresetn)
    inj_bits && bits_code <= BITS_CODE_MAX |=> bits_per_word == BITS_BASE + 5'($past(bits_code)))
    else $error("bit count does not follow code");
  a_words_exact: assert property (@(posedge aclk) disable iff (!aresetn)
    !inj_words && cmd_wc != '0 |=> data_words == {1'b0, $past(cmd_wc)})
    else $error("word count altered without injection");
endmodule : injection_shaper
`default_nettype wire

/* File: design/bc_message_control_regs.sv */
// Message control register bank: AXI4-Lite slave, event flags, timers, injection
`timescale 1ns/1ps
`default_nettype none
module bc_message_control_regs
  import bcregs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [15:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [15:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Message engine
  input  wire logic        msg_done,
  input  wire logic        msg_error,
  input  wire logic        frame_last,
  input  wire logic        halt_seen,
  input  wire logic        halt_flag,
  input  wire logic        engine_busy,
  input  wire logic        inj_bits,
  input  wire logic        inj_words,
  input  wire logic [4:0]  cmd_wc,
  input  wire logic        rt_wait_start,
  input  wire logic        bc_wait_start,
  input  wire logic        bc_response_seen,
  output logic             run,
  output logic             paused,
  output logic             halted,
  output logic             irq,
  output logic      [4:0]  bits_per_word,
  output logic      [5:0]  data_words,
  output logic             rt_reply_go,
  output logic             bc_no_response
);
  typedef struct packed {
    logic        aw_got;
    logic [13:0] aw_idx;
    logic        w_got;
    logic [7:0]  wdata;
    logic        wlane;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
    logic [7:0]  bc_win;
    logic [7:0]  wc_ofs;
    logic [7:0]  bits_sel;
    logic [7:0]  repeat_cnt;
    logic [7:0]  rt_dly;
    logic [7:0]  flags;
    logic [7:0]  irq_en;
    logic [7:0]  start;
    logic [7:0]  loops_left;
    logic        halted;
    logic        irq_armed;
    logic        irq;
  } regs_t;

  regs_t      s_r;
  regs_t      s_nxt;
  logic       wr_fire;
  logic       clr_fire;
  logic [7:0] ev_set;
  logic       stop_now;

  // Every index that answers OKAY
  function automatic logic is_mapped(input logic [13:0] idx);
    case (idx)
      IDX_BC_WIN, IDX_WC_OFS, IDX_BITS_SEL, IDX_REPEAT, IDX_FLAG_CLR, IDX_IRQ_RST,
      IDX_RT_DLY, IDX_FLAGS, IDX_IRQ_EN, IDX_START, IDX_STATUS: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // Bus handshakes; a held response blocks new writes or reads
  assign awready = !s_r.aw_got && !s_r.bvalid;
  assign wready  = !s_r.w_got && !s_r.bvalid;
  assign arready = !s_r.rvalid;
  assign wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign stop_now = !s_r.start[START_RUN];

  // Next-state logic for bus, configuration and events
  always_comb begin
    s_nxt    = s_r;
    clr_fire = 1'b0;
    ev_set   = '0;
    // Address and data may arrive in either order
    if (awvalid && awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_idx = awaddr[15:2];
    end
    if (wvalid && wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = wdata[7:0];
      s_nxt.wlane = wstrb[0];
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // Halted once stopped and the engine has gone quiet
    if (stop_now && !engine_busy) begin
      s_nxt.halted = 1'b1;
    end
    // Frame end: one-shot stops, counted loop stops when used up
    if (msg_done && frame_last && s_r.start[START_RUN]) begin
      if (!s_r.start[START_LOOP]) begin
        s_nxt.start[START_RUN] = 1'b0;
      end else if (s_r.repeat_cnt != '0) begin
        if (s_r.loops_left <= 8'h01) begin
          s_nxt.start[START_RUN] = 1'b0;
        end else begin
          s_nxt.loops_left = s_r.loops_left - 8'h01;
        end
      end
    end
    // Register write; data sits in byte lane 0
    if (wr_fire) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = is_mapped(s_r.aw_idx) ? RESP_OKAY : RESP_SLVERR;
      // Interrupt reset ignores the data entirely
      if (s_r.aw_idx == IDX_IRQ_RST) begin
        s_nxt.irq_armed = 1'b0;
      end
      // Settings are taken as written, except irq_en and start, which are masked to IRQ_MASK and START_MASK; software stops first
      if (s_r.wlane) begin
        case (s_r.aw_idx)
          IDX_BC_WIN:   s_nxt.bc_win = s_r.wdata;
          IDX_WC_OFS:   s_nxt.wc_ofs = s_r.wdata;
          IDX_BITS_SEL: s_nxt.bits_sel = s_r.wdata;
          IDX_REPEAT:   s_nxt.repeat_cnt = s_r.wdata;
          IDX_RT_DLY:   s_nxt.rt_dly = s_r.wdata;
          IDX_IRQ_EN:   s_nxt.irq_en = s_r.wdata & IRQ_MASK;
          IDX_FLAG_CLR: clr_fire = 1'b1;
          IDX_START: begin
            s_nxt.start = s_r.wdata & START_MASK;
            if (s_r.wdata[START_RUN]) begin
              s_nxt.halted     = 1'b0;
              s_nxt.loops_left = s_r.repeat_cnt;
            end
          end
          default: s_nxt.start = s_nxt.start;
        endcase
      end
    end
    // Done, end-of-frame and error only at message end, wait on any halt_seen; set beats a same-cycle clear
    if (halt_seen) begin
      ev_set[FLG_WAIT] = 1'b1;
    end
    if (msg_done) begin
      ev_set[FLG_DONE] = 1'b1;
      ev_set[FLG_EOF]  = frame_last;
      ev_set[FLG_ERR]  = msg_error;
    end
    if (clr_fire) begin
      s_nxt.flags = s_r.flags & ~(s_r.wdata & FLAGS_MASK);
    end
    s_nxt.flags = s_nxt.flags | ev_set;
    // A fresh enabled event re-arms after an interrupt reset
    if (|(ev_set & s_r.irq_en & IRQ_MASK)) begin
      s_nxt.irq_armed = 1'b1;
    end
    s_nxt.irq = s_nxt.irq_armed && |(s_nxt.flags & s_nxt.irq_en & IRQ_MASK);
    // Read path; write-only locations read as zero
    if (arvalid && arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = is_mapped(araddr[15:2]) ? RESP_OKAY : RESP_SLVERR;
      case (araddr[15:2])
        IDX_BC_WIN:   s_nxt.rdata = s_r.bc_win;
        IDX_WC_OFS:   s_nxt.rdata = s_r.wc_ofs;
        IDX_BITS_SEL: s_nxt.rdata = s_r.bits_sel;
        IDX_REPEAT:   s_nxt.rdata = s_r.repeat_cnt;
        IDX_RT_DLY:   s_nxt.rdata = s_r.rt_dly;
        IDX_FLAGS:    s_nxt.rdata = s_r.flags;
        IDX_IRQ_EN:   s_nxt.rdata = s_r.irq_en;
        IDX_START:    s_nxt.rdata = s_r.start;
        IDX_STATUS:   s_nxt.rdata = 8'(s_r.halted) << STAT_HALT;
        default:      s_nxt.rdata = '0;
      endcase
    end
  end

  // State register; halted reads one out of reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '{halted: 1'b1, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign bvalid = s_r.bvalid;
  assign bresp  = s_r.bresp;
  assign rvalid = s_r.rvalid;
  assign rresp  = s_r.rresp;
  assign rdata  = {24'h0, s_r.rdata};
  assign run    = s_r.start[START_RUN];
  assign halted = s_r.halted;
  assign irq    = s_r.irq;
  // Engine holds while the wait flag is set and software has not yet cleared the halt in memory
  assign paused = s_r.flags[FLG_WAIT] && halt_flag;

  // Simulated RT reply dead time; a stop aborts it
  dead_time_timer #(
    .BASE_CYC (RT_MIN_CYC)
  ) u_rt_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (rt_wait_start),
    .cancel  (stop_now),
    .steps   (s_r.rt_dly),
    .expire  (rt_reply_go)
  );

  // BC status-response window; any reply cancels the timeout
  dead_time_timer #(
    .BASE_CYC (BC_MIN_CYC)
  ) u_bc_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (bc_wait_start),
    .cancel  (bc_response_seen || stop_now),
    .steps   (s_r.bc_win),
    .expire  (bc_no_response)
  );

  // Word shaping for injected errors
  injection_shaper u_shaper (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .inj_bits      (inj_bits),
    .inj_words     (inj_words),
    .bits_code     (s_r.bits_sel[2:0]),
    .cmd_wc        (cmd_wc),
    .wc_ofs        (s_r.wc_ofs),
    .bits_per_word (bits_per_word),
    .data_words    (data_words)
  );

  a_irq_enabled: assert property (@(posedge aclk) disable iff (!aresetn)
    irq |-> |(s_r.flags & s_r.irq_en & IRQ_MASK))
    else $error("interrupt without enabled flag");
  a_irq_msg_end: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(irq) |-> $past(msg_done))
    else $error("interrupt rose outside message end");
  a_err_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    msg_done && msg_error |=> s_r.flags[FLG_ERR])
    else $error("message error flag not set");
  a_eof_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    msg_done && frame_last |=> s_r.flags[FLG_EOF])
    else $error("end of frame flag not set");
  a_done_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    msg_done |=> s_r.flags[FLG_DONE] ##0 !$stable(s_r.flags) or $past(s_r.flags[FLG_DONE]))
    else $error("message complete flag not set");
  a_wait_pause: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_seen ##1 halt_flag |-> paused)
    else $error("halted message did not pause");
  a_flags_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(clr_fire) |-> (s_r.flags & $past(s_r.flags)) == $past(s_r.flags))
    else $error("flag dropped without clear write");
  a_one_shot_end: assert property (@(posedge aclk) disable iff (!aresetn)
    msg_done && frame_last && run && !s_r.start[START_LOOP] && !wr_fire |=> !run)
    else $error("one-shot frame did not stop");
  a_endless_loop: assert property (@(posedge aclk) disable iff (!aresetn)
    msg_done && run && s_r.start[START_LOOP] && s_r.repeat_cnt == '0 && !wr_fire |=> run)
    else $error("continuous loop stopped itself");
  a_halt_start: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && s_r.wlane && s_r.aw_idx == IDX_START && s_r.wdata[START_RUN] |=> !halted)
    else $error("start did not clear halted");
endmodule : bc_message_control_regs
`default_nettype wire

/* File: bench/msg_engine_model.sv */
// Message engine and remote terminal stand-in for the engine-side ports
`timescale 1ns/1ps
`default_nettype none
module msg_engine_model (
  input  wire logic aclk,
  output logic      msg_done,
  output logic      msg_error,
  output logic      frame_last,
  output logic      halt_seen,
  output logic      halt_flag,
  output logic      engine_busy,
  output logic      rt_wait_start,
  output logic      bc_wait_start,
  output logic      bc_response_seen
);
  initial begin
    {msg_done, msg_error, frame_last, halt_seen, halt_flag, engine_busy} = '0;
    {rt_wait_start, bc_wait_start, bc_response_seen} = '0;
  end

  // One message: busy over its words, completion only after the last one
  task automatic send_message(input logic err, input logic last);
    @(posedge aclk);
    engine_busy <= 1'b1;
    msg_error   <= err;
    frame_last  <= last;
    repeat (4) @(posedge aclk);
    msg_done <= 1'b1;
    @(posedge aclk);
    msg_done    <= 1'b0;
    engine_busy <= 1'b0;
    // Qualifiers lapse; show the inverse rather than a stale copy
    msg_error   <= ~err;
    frame_last  <= ~last;
  endtask : send_message

  // Halt bit stays in the control word until software clears it
  task automatic meet_halt(input logic flag);
    @(posedge aclk);
    halt_flag <= flag;
    halt_seen <= flag;
    @(posedge aclk);
    halt_seen <= 1'b0;
  endtask : meet_halt

  // One-cycle pulse: 0 RT wait, 1 BC window, else response arrived
  task automatic pulse(input int sel);
    @(posedge aclk);
    case (sel)
      0: rt_wait_start <= 1'b1;
      1: bc_wait_start <= 1'b1;
      default: bc_response_seen <= 1'b1;
    endcase
    @(posedge aclk);
    {rt_wait_start, bc_wait_start, bc_response_seen} <= '0;
  endtask : pulse
endmodule : msg_engine_model
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the message control register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb;
  import bcregs_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, inj_bits, inj_words;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [4:0]  cmd_wc;
  wire logic   awready, wready, bvalid, arready, rvalid, run, paused, halted, irq;
  wire logic   rt_reply_go, bc_no_response, msg_done, msg_error, frame_last, halt_seen;
  wire logic   halt_flag, engine_busy, rt_wait_start, bc_wait_start, bc_response_seen;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [4:0]  bits_per_word;
  wire logic [5:0]  data_words;
  int          n_errors, n_checks, cyc;
  logic [1:0]  r;

  bc_message_control_regs i_bc_message_control_regs (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .msg_done, .msg_error, .frame_last, .halt_seen, .halt_flag, .engine_busy,
    .inj_bits, .inj_words, .cmd_wc, .rt_wait_start, .bc_wait_start, .bc_response_seen, .run, .paused,
    .halted, .irq, .bits_per_word, .data_words, .rt_reply_go, .bc_no_response);
  msg_engine_model i_msg_engine_model (.aclk, .msg_done, .msg_error, .frame_last, .halt_seen,
    .halt_flag, .engine_busy, .rt_wait_start, .bc_wait_start, .bc_response_seen);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Hang guard: the tests need roughly 7000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  // Handshakes are judged mid-cycle so the edge that takes them is known
  task automatic wr(input logic [13:0] idx, input logic [7:0] d, output logic [1:0] resp);
    logic a, w, b;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge aclk);
      a = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (b) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [13:0] idx, output logic [31:0] d, output logic [1:0] resp);
    logic a, v;
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 100; i++) begin
      @(negedge aclk);
      a = arvalid & arready;
      v = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge aclk);
      if (a) arvalid <= 1'b0;
      if (v) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd

  task automatic chk_rd(input string nm, input logic [13:0] idx, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  q;
    rd(idx, d, q);
    `CHK(nm, {24'h0, e}, d)
    `CHK("read resp", RESP_OKAY, q)
  endtask : chk_rd

  task automatic t_reset();
    @(negedge aclk);
    `CHK("halted", 1'b1, halted)
    `CHK("irq", 1'b0, irq)
    chk_rd("status", IDX_STATUS, 8'h10);
    chk_rd("flags", IDX_FLAGS, 8'h00);
    $display("reset test done");
  endtask : t_reset

  // Read-back of every RW register except start, read-only flags, unmapped place
  task automatic t_regs();
    logic [13:0] ix[6] = '{IDX_BC_WIN, IDX_WC_OFS, IDX_BITS_SEL, IDX_REPEAT, IDX_RT_DLY, IDX_IRQ_EN};
    logic [7:0]  ex[6] = '{8'ha5, 8'ha5, 8'ha5, 8'ha5, 8'ha5, 8'h04};
    logic [31:0] d;
    for (int i = 0; i < 6; i++) begin
      wr(ix[i], 8'ha5, r);
      chk_rd("register", ix[i], ex[i]);
    end
    // Byte lane 0 disabled: the write must leave the register alone
    wstrb <= 4'h0;
    wr(IDX_RT_DLY, 8'h3c, r);
    chk_rd("lane off", IDX_RT_DLY, 8'ha5);
    wstrb <= 4'h1;
    wr(IDX_FLAGS, 8'hff, r);
    chk_rd("flags ro", IDX_FLAGS, 8'h00);
    wr(14'h0100, 8'h11, r);
    `CHK("unmapped wr", RESP_SLVERR, r)
    rd(14'h0100, d, r);
    `CHK("unmapped rd", RESP_SLVERR, r)
    $display("register test done");
  endtask : t_regs

  task automatic t_events();
    wr(IDX_IRQ_EN, 8'h0e, r);
    fork
      i_msg_engine_model.send_message(1'b1, 1'b1);
      begin
        repeat (3) @(negedge aclk);
        `CHK("irq mid message", 1'b0, irq)
      end
    join
    repeat (2) @(negedge aclk);
    `CHK("irq", 1'b1, irq)
    chk_rd("flags", IDX_FLAGS, 8'h0e);
    wr(IDX_IRQ_RST, 8'h00, r);
    @(negedge aclk);
    `CHK("irq reset", 1'b0, irq)
    chk_rd("flags kept", IDX_FLAGS, 8'h0e);
    wr(IDX_FLAG_CLR, 8'h0f, r);
    chk_rd("flags cleared", IDX_FLAGS, 8'h00);
    // Only errors enabled: a clean mid-frame message stays silent
    wr(IDX_IRQ_EN, 8'h08, r);
    i_msg_engine_model.send_message(1'b0, 1'b0);
    repeat (2) @(negedge aclk);
    `CHK("irq masked", 1'b0, irq)
    chk_rd("flags done", IDX_FLAGS, 8'h02);
    i_msg_engine_model.meet_halt(1'b1);
    @(negedge aclk);
    `CHK("paused", 1'b1, paused)
    chk_rd("flags wait", IDX_FLAGS, 8'h03);
    i_msg_engine_model.meet_halt(1'b0);
    @(negedge aclk);
    `CHK("resumed", 1'b0, paused)
    wr(IDX_FLAG_CLR, 8'h0f, r);
    $display("event test done");
  endtask : t_events

  task automatic t_shape();
    logic signed [7:0] ofs[7] = '{8'shfd, 8'shfe, 8'shff, 8'sh00, 8'sh01, 8'sh02, 8'sh03};
    // Code 7 is undefined and must still give a valid word
    for (int c = 0; c < 8; c++) begin
      wr(IDX_BITS_SEL, 8'(c), r);
      inj_bits <= 1'b1;
      repeat (2) @(negedge aclk);
      `CHK("bits", (c == 7) ? BITS_NORMAL : 5'(17 + c), bits_per_word)
    end
    @(posedge aclk);
    inj_bits <= 1'b0;
    repeat (2) @(negedge aclk);
    `CHK("bits plain", BITS_NORMAL, bits_per_word)
    for (int i = 0; i < 7; i++) begin
      wr(IDX_WC_OFS, ofs[i], r);
      inj_words <= 1'b1;
      repeat (2) @(negedge aclk);
      `CHK("words", 6'(10 + ofs[i]), data_words)
    end
    @(posedge aclk);
    inj_words <= 1'b0;
    repeat (2) @(negedge aclk);
    `CHK("words plain", 6'h0a, data_words)
    // A zero word-count field stands for a full 32-word message
    @(posedge aclk);
    cmd_wc <= 5'h00;
    repeat (2) @(negedge aclk);
    `CHK("words full", WC_FULL, data_words)
    @(posedge aclk);
    cmd_wc <= 5'h0a;
    $display("shaping test done");
  endtask : t_shape

  task automatic t_loop();
    wr(IDX_REPEAT, 8'h02, r);
    wr(IDX_START, 8'h05, r);
    chk_rd("status run", IDX_STATUS, 8'h00);
    i_msg_engine_model.send_message(1'b0, 1'b1);
    @(negedge aclk);
    `CHK("run first", 1'b1, run)
    i_msg_engine_model.send_message(1'b0, 1'b1);
    @(negedge aclk);
    `CHK("run second", 1'b0, run)
    chk_rd("status stop", IDX_STATUS, 8'h10);
    wr(IDX_START, 8'h01, r);
    i_msg_engine_model.send_message(1'b0, 1'b1);
    @(negedge aclk);
    `CHK("run one shot", 1'b0, run)
    wr(IDX_FLAG_CLR, 8'h0f, r);
    $display("loop test done");
  endtask : t_loop

  // Stop, set the delay, restart in continuous loop, time the dead time
  task automatic measure(input int sel, input logic [13:0] idx, input logic [7:0] d, input int base);
    int n;
    int e;
    wr(IDX_START, 8'h00, r);
    wr(idx, d, r);
    wr(IDX_START, 8'h05, r);
    i_msg_engine_model.pulse(sel);
    e = (base + int'(d) * 155) / 8;
    for (n = 1; n < 3000; n++) begin
      @(negedge aclk);
      if ((sel == 0 ? rt_reply_go : bc_no_response) === 1'b1) break;
    end
    `CHK("dead time in band", 1'b1, (n >= e - 125 && n <= e + 125))
  endtask : measure

  task automatic t_timers();
    int hits;
    wr(IDX_REPEAT, 8'h00, r);
    measure(0, IDX_RT_DLY, 8'h00, RT_MIN_NS);
    measure(0, IDX_RT_DLY, 8'h20, RT_MIN_NS);
    measure(1, IDX_BC_WIN, 8'h00, BC_MIN_NS);
    measure(1, IDX_BC_WIN, 8'h5a, BC_MIN_NS);
    i_msg_engine_model.send_message(1'b0, 1'b1);
    i_msg_engine_model.send_message(1'b0, 1'b1);
    @(negedge aclk);
    `CHK("run continuous", 1'b1, run)
    i_msg_engine_model.pulse(1);
    repeat (100) @(posedge aclk);
    i_msg_engine_model.pulse(2);
    hits = 0;
    repeat (2500) begin
      @(negedge aclk);
      if (bc_no_response === 1'b1) hits++;
    end
    `CHK("window cancelled", 0, hits)
    wr(IDX_START, 8'h00, r);
    chk_rd("status halted", IDX_STATUS, 8'h10);
    $display("timer test done");
  endtask : t_timers

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, inj_bits, inj_words} = '0;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h0000_0000;
    wstrb = 4'h1;
    cmd_wc = 5'h0a;
    n_errors = 0;
    n_checks = 0;
    cyc = 0;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_regs();
    t_events();
    t_shape();
    t_loop();
    t_timers();
    results();
  end
endmodule : tb
`default_nettype wire
